// *** design/brts_map.svh ***
// brts_map: register indices, field positions, reset values and timing counts
// assumes inclusion by bare name from the sequencer files
`ifndef BRTS_MAP_SVH
`define BRTS_MAP_SVH
`define BRTS_POWER_CONTROL_STATUS_IDX 10'h08e
`define BRTS_STAT_IDX 10'h083
`define BRTS_CFG_IDX 10'h08f
`define BRTS_POWER_CONTROL_STATUS_ULPWU 5
`define BRTS_POWER_CONTROL_STATUS_SBOR 4
`define BRTS_POWER_CONTROL_STATUS_WUR 3
`define BRTS_POWER_CONTROL_STATUS_POR 1
`define BRTS_POWER_CONTROL_STATUS_BOR 0
`define BRTS_STAT_TO 4
`define BRTS_STAT_PD 3
`define BRTS_CFG_MODE_HI 9
`define BRTS_CFG_MODE_LO 8
`define BRTS_CFG_POWERUP_DELAY_DISABLE_N 4
`define BRTS_CFG_FOSC_HI 2
`define BRTS_FOSC_XTAL_MAX 3'h2
`define BRTS_POWER_CONTROL_STATUS_RST 8'h10
`define BRTS_STAT_RST 8'h18
`define BRTS_MCLK_NS 100
`define BRTS_POWERUP_DELAY_TIMER_MS 64
`define BRTS_LFOSC_HZ 31000
`define BRTS_POWERUP_DELAY_TIMER_TICKS (`BRTS_POWERUP_DELAY_TIMER_MS * `BRTS_LFOSC_HZ / 1000)
`define BRTS_OST_TICKS 1024
`define BRTS_BOD_MIN_NS 2000
`define BRTS_BOD_CYC ((`BRTS_BOD_MIN_NS + `BRTS_MCLK_NS - 1) / `BRTS_MCLK_NS)
`endif

// *** design/brts_pkg.sv ***
// brts_pkg: types shared by the sequencer
// assumes nothing beyond the map header for numbers
package brts_pkg;
	typedef enum logic [1:0] {brts_bor_off, brts_bor_sw, brts_bor_nosleep, brts_bor_on} brts_bor_mode_e;
	typedef enum logic [2:0] {st_por, st_supply, st_powerup_delay_timer, st_ost, st_wake, st_run} brts_state_e;
endpackage

// *** design/brts_sync.sv ***
// brts_sync: two-flop synchroniser, one chain per bit
// assumes asynchronous inputs and the mclk domain
`timescale 1ns/1ns
module brts_sync #(
	parameter int N = 4
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [N-1:0] d,
	output logic [N-1:0] q
);
	logic [N-1:0] meta_r;
	for (genvar i = 0; i < N; i++) begin : g_bit
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				meta_r[i] <= 1'b0;
				q[i] <= 1'b0;
			end else begin
				meta_r[i] <= d[i];
				q[i] <= meta_r[i];
			end
		end
	end
endmodule

// *** design/brts_timer.sv ***
// brts_timer: tick counter that saturates at a terminal count
// assumes tick is a one-cycle strobe in the mclk domain
`timescale 1ns/1ns
module brts_timer #(
	parameter int W = 16,
	parameter int MAX = 1024
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clear,
	input wire logic tick,
	output logic done
);
	logic [W-1:0] cnt_r;
	if (MAX < 1 || MAX >= (2 ** W)) begin : g_chk
		$error("brts_timer: terminal count out of range");
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (clear) begin
			cnt_r <= '0;
		end else if (tick && !done) begin
			cnt_r <= cnt_r + W'(1);
		end
	end
	assign done = (cnt_r == W'(MAX));
endmodule

// *** design/brts_seq.sv ***
// brts_seq: brown-out, power-up delay and start-up time-out sequencer with cause flags
// assumes a 10 MHz mclk, an avalon-mm master, oscillator levels arriving as plain inputs
// What this block does
// - mode field 01 lets the software enable bit alone switch brown-out detection
// - sleep-gated mode turns detection off in sleep, ignores software enable
// - a dip longer than the minimum duration, while enabled, causes brown-out reset
// - power-on, brown-out, watchdog and wake resets hold until supply is good, then power-up delay if enabled
// - a dip during the power-up delay re-enters brown-out and restarts the delay
// - power-up delay starts after the power-on pulse; start-up timer after the delay
// - crystal modes add 1024 oscillator periods; wake from sleep waits 1024 periods
// - rc, external clock, internal modes use only the delay; none on wake
// - timers run regardless of the reset pin; pin release then starts at once
// - two-speed start-up runs from the internal oscillator during start-up counting
// - bit 0 cleared by brown-out reset; software sets and tests it
// - bit 1 reads 0 after power-on only; software writes 1 afterwards
// - control register 01qq on power-on or brown-out, 0uuu otherwise; status likewise
// - mode at config bits 9:8, delay disable bit 4; control bits 5, 4, 3
// - power-on and brown-out resets clear their flag, set timeout and powerdown flags
// - watchdog reset clears timeout; watchdog wake clears both; pin reset changes none
// - pin reset in sleep gives timeout 1, powerdown 0; wake reset also clears its flag
// - power-up delay counts ticks of the 31 khz low-frequency oscillator
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ns
`include "brts_map.svh"
module brts_seq #(
	parameter int POWERUP_DELAY_TIMER_TICKS = `BRTS_POWERUP_DELAY_TIMER_TICKS,
	parameter int OST_TICKS = `BRTS_OST_TICKS,
	parameter int BOD_CYC = `BRTS_BOD_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic por_pulse,
	input wire logic brownout_below,
	input wire logic ext_reset_pin_n,
	input wire logic low_freq_internal_osc,
	input wire logic osc_clk_in,
	input wire logic sleep_active,
	input wire logic wdt_timeout,
	input wire logic wake_event,
	input wire logic wake_reset_event,
	input wire logic two_speed_en,
	input wire logic [9:0] cfg_word,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic core_reset,
	output logic core_stall,
	output logic run_on_internal_osc
);
	if (POWERUP_DELAY_TIMER_TICKS < 1 || POWERUP_DELAY_TIMER_TICKS > 65535 || OST_TICKS < 1 || OST_TICKS > 65535
		|| BOD_CYC < 1 || BOD_CYC > 65535) begin : g_chk
		$error("brts_seq: timing count out of range");
	end

	brts_pkg::brts_state_e st_r;
	brts_pkg::brts_state_e st_nxt;
	brts_pkg::brts_bor_mode_e mode;
	logic [9:0] cfg_r;
	logic [3:0] sync_q;
	logic pin_s, bod_s, lf_s, osc_s;
	logic pin_prev_r, lf_prev_r, osc_prev_r;
	logic lf_edge, osc_edge, ext_reset_pin_n_evt;
	logic bor_en, bor_trip, powerup_delay_timer_done, ost_done;
	logic xtal, powerup_delay_timer_on, wdt_rst, wdt_wake, wur_go, wake_go, reset_go, hold;
	logic ulp_r, sbor_r, wur_r, por_r, bor_r;
	logic [2:0] stat_hi_r, stat_lo_r;
	logic to_r, pd_r;
	logic req, wr_go, wr_lo;
	logic [9:0] idx;
	logic [31:0] rd_mux;

	// synchronise pin, comparator and oscillator levels
	brts_sync #(.N(4)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.d({osc_clk_in, low_freq_internal_osc, brownout_below, ext_reset_pin_n}),
		.q(sync_q)
	);
	assign pin_s = sync_q[0];
	assign bod_s = sync_q[1];
	assign lf_s = sync_q[2];
	assign osc_s = sync_q[3];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_prev_r <= 1'b0;
			lf_prev_r <= 1'b0;
			osc_prev_r <= 1'b0;
		end else begin
			pin_prev_r <= pin_s;
			lf_prev_r <= lf_s;
			osc_prev_r <= osc_s;
		end
	end
	assign lf_edge = lf_s && !lf_prev_r;
	assign osc_edge = osc_s && !osc_prev_r;
	assign ext_reset_pin_n_evt = pin_prev_r && !pin_s;

	// configuration word captured while the power-on pulse holds the sequencer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_r <= 10'h000;
		end else if (st_r == brts_pkg::st_por) begin
			cfg_r <= cfg_word;
		end
	end
	assign mode = brts_pkg::brts_bor_mode_e'(cfg_r[`BRTS_CFG_MODE_HI:`BRTS_CFG_MODE_LO]);
	assign powerup_delay_timer_on = !cfg_r[`BRTS_CFG_POWERUP_DELAY_DISABLE_N];
	assign xtal = (cfg_r[`BRTS_CFG_FOSC_HI:0] <= `BRTS_FOSC_XTAL_MAX);

	// brown-out enable per mode
	always_comb begin
		case (mode)
			brts_pkg::brts_bor_off: bor_en = 1'b0;
			brts_pkg::brts_bor_sw: bor_en = sbor_r;
			brts_pkg::brts_bor_nosleep: bor_en = !sleep_active;
			brts_pkg::brts_bor_on: bor_en = 1'b1;
			default: bor_en = 1'b0;
		endcase
	end

	// minimum-duration filter on the comparator
	brts_timer #(.W(16), .MAX(BOD_CYC)) u_bod (
		.mclk(mclk),
		.rst(rst),
		.clear(!(bor_en && bod_s)),
		.tick(1'b1),
		.done(bor_trip)
	);

	// power-up delay on low-frequency oscillator ticks
	brts_timer #(.W(16), .MAX(POWERUP_DELAY_TIMER_TICKS)) u_powerup_delay_timer (
		.mclk(mclk),
		.rst(rst),
		.clear(st_r != brts_pkg::st_powerup_delay_timer),
		.tick(lf_edge),
		.done(powerup_delay_timer_done)
	);

	// oscillator start-up count
	brts_timer #(.W(16), .MAX(OST_TICKS)) u_ost (
		.mclk(mclk),
		.rst(rst),
		.clear(st_r != brts_pkg::st_ost && st_r != brts_pkg::st_wake),
		.tick(osc_edge),
		.done(ost_done)
	);

	assign wdt_rst = wdt_timeout && !sleep_active;
	assign wdt_wake = wdt_timeout && sleep_active;
	assign wur_go = wake_reset_event && sleep_active;
	assign wake_go = wake_event || wdt_wake;
	assign reset_go = bor_trip || wdt_rst || wur_go;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			brts_pkg::st_por: begin
				if (!por_pulse) begin
					st_nxt = brts_pkg::st_supply;
				end
			end
			brts_pkg::st_supply: begin
				if (!bod_s) begin
					if (powerup_delay_timer_on) begin
						st_nxt = brts_pkg::st_powerup_delay_timer;
					end else if (xtal) begin
						st_nxt = brts_pkg::st_ost;
					end else begin
						st_nxt = brts_pkg::st_run;
					end
				end
			end
			brts_pkg::st_powerup_delay_timer: begin
				if (powerup_delay_timer_done) begin
					st_nxt = xtal ? brts_pkg::st_ost : brts_pkg::st_run;
				end
			end
			brts_pkg::st_ost, brts_pkg::st_wake: begin
				if (ost_done) begin
					st_nxt = brts_pkg::st_run;
				end
			end
			brts_pkg::st_run: begin
				if (wake_go && xtal) begin
					st_nxt = brts_pkg::st_wake;
				end
			end
			default: st_nxt = brts_pkg::st_por;
		endcase
		if (reset_go) begin
			st_nxt = brts_pkg::st_supply;
		end
		if (por_pulse) begin
			st_nxt = brts_pkg::st_por;
		end
	end

	// the pin never restarts the timers, it only holds the core
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r <= brts_pkg::st_por;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hold = por_pulse || !pin_s || (st_r != brts_pkg::st_run && st_r != brts_pkg::st_wake
		&& !(st_r == brts_pkg::st_ost && two_speed_en));

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			core_reset <= 1'b1;
			core_stall <= 1'b0;
			run_on_internal_osc <= 1'b0;
		end else begin
			core_reset <= hold;
			core_stall <= (st_r == brts_pkg::st_wake) && !two_speed_en;
			run_on_internal_osc <= (st_r == brts_pkg::st_ost || st_r == brts_pkg::st_wake)
				&& two_speed_en;
		end
	end

	// bus slave: one wait cycle, then the access completes
	assign req = avs_read || avs_write;
	assign idx = avs_address[11:2];
	assign wr_go = avs_write && !avs_waitrequest;
	assign wr_lo = wr_go && avs_byteenable[0];

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (idx)
			`BRTS_POWER_CONTROL_STATUS_IDX: rd_mux[7:0] = {2'h0, ulp_r, sbor_r, wur_r, 1'b0, por_r, bor_r};
			`BRTS_STAT_IDX: rd_mux[7:0] = {stat_hi_r, to_r, pd_r, stat_lo_r};
			`BRTS_CFG_IDX: rd_mux[9:0] = cfg_r;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if (req && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= rd_mux;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// control register: software write first, hardware events override it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{ulp_r, sbor_r} <= 2'h1;
			wur_r <= 1'b0;
			por_r <= 1'b0;
			bor_r <= 1'b0;
		end else begin
			if (wr_lo && idx == `BRTS_POWER_CONTROL_STATUS_IDX) begin
				ulp_r <= avs_writedata[`BRTS_POWER_CONTROL_STATUS_ULPWU];
				sbor_r <= avs_writedata[`BRTS_POWER_CONTROL_STATUS_SBOR];
				wur_r <= avs_writedata[`BRTS_POWER_CONTROL_STATUS_WUR];
				por_r <= avs_writedata[`BRTS_POWER_CONTROL_STATUS_POR];
				bor_r <= avs_writedata[`BRTS_POWER_CONTROL_STATUS_BOR];
			end
			if (wdt_rst || ext_reset_pin_n_evt || wur_go) begin
				ulp_r <= 1'b0;
			end
			if (wur_go) begin
				wur_r <= 1'b0;
			end
			if (bor_trip) begin
				ulp_r <= 1'b0;
				sbor_r <= 1'b1;
				bor_r <= 1'b0;
			end
			if (por_pulse) begin
				ulp_r <= 1'b0;
				sbor_r <= 1'b1;
				por_r <= 1'b0;
			end
		end
	end

	// status register cause flags
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{stat_hi_r, to_r, pd_r, stat_lo_r} <= `BRTS_STAT_RST;
		end else begin
			if (wr_lo && idx == `BRTS_STAT_IDX) begin
				stat_hi_r <= avs_writedata[7:5];
				stat_lo_r <= avs_writedata[2:0];
			end
			if (ext_reset_pin_n_evt && !sleep_active) begin
				stat_hi_r <= 3'h0;
			end
			if (wdt_rst) begin
				stat_hi_r <= 3'h0;
				to_r <= 1'b0;
			end
			if (wdt_wake) begin
				to_r <= 1'b0;
				pd_r <= 1'b0;
			end
			if ((ext_reset_pin_n_evt && sleep_active) || wur_go) begin
				stat_hi_r <= 3'h0;
				to_r <= 1'b1;
				pd_r <= 1'b0;
			end
			if (por_pulse || bor_trip) begin
				stat_hi_r <= 3'h0;
				to_r <= 1'b1;
				pd_r <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_sw_mode;
		mode == brts_pkg::brts_bor_sw |-> bor_en == sbor_r;
	endproperty
	a_sw_mode: assert property (p_sw_mode) else $error("sw mode enable mismatch");

	property p_sleep_gate;
		mode == brts_pkg::brts_bor_nosleep && sleep_active |-> !bor_en && !bor_trip ##0 1'b1;
	endproperty
	a_sleep_gate: assert property (p_sleep_gate) else $error("brown-out active in sleep");

	property p_bod_filter;
		!(bor_en && bod_s) |=> !bor_trip;
	endproperty
	a_bod_filter: assert property (p_bod_filter) else $error("brown-out trip without dip");

	property p_supply_hold;
		st_r == brts_pkg::st_supply && bod_s && !por_pulse |=> st_r == brts_pkg::st_supply;
	endproperty
	a_supply_hold: assert property (p_supply_hold) else $error("left supply hold while low");

	sequence s_powerup_delay_timer_abort;
		st_r == brts_pkg::st_powerup_delay_timer && bor_trip && !por_pulse;
	endsequence
	sequence s_powerup_delay_timer_reinit;
		st_r == brts_pkg::st_supply ##1 !powerup_delay_timer_done;
	endsequence
	property p_powerup_delay_timer_restart;
		s_powerup_delay_timer_abort |=> s_powerup_delay_timer_reinit;
	endproperty
	a_powerup_delay_timer_restart: assert property (p_powerup_delay_timer_restart) else $error("delay not restarted");

	property p_ost_after_powerup_delay_timer;
		st_r == brts_pkg::st_powerup_delay_timer ##1 st_r == brts_pkg::st_ost |-> $past(powerup_delay_timer_done);
	endproperty
	a_ost_after_powerup_delay_timer: assert property (p_ost_after_powerup_delay_timer) else $error("start-up before delay end");

	property p_ost_xtal;
		st_r == brts_pkg::st_ost || st_r == brts_pkg::st_wake |-> xtal;
	endproperty
	a_ost_xtal: assert property (p_ost_xtal) else $error("start-up count in non-crystal mode");

	property p_rc_direct;
		st_r == brts_pkg::st_powerup_delay_timer && powerup_delay_timer_done && !xtal && !reset_go && !por_pulse
			|=> st_r == brts_pkg::st_run;
	endproperty
	a_rc_direct: assert property (p_rc_direct) else $error("extra time-out in rc mode");

	property p_pin_release;
		!pin_s ##1 (pin_s && st_r == brts_pkg::st_run && !por_pulse) |=> !core_reset;
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("pin release not immediate");

	property p_por_flags;
		por_pulse |=> !por_r && to_r && pd_r && sbor_r && !ulp_r;
	endproperty
	a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");

	property p_wdt_flag;
		wdt_rst && !por_pulse && !bor_trip |=> !to_r;
	endproperty
	a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not cleared");

	property p_pin_hold;
		!pin_s |=> core_reset;
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("reset released with pin low");

	property p_pin_sync;
		!ext_reset_pin_n [*3] |-> !pin_s;
	endproperty
	a_pin_sync: assert property (p_pin_sync) else $error("pin synchroniser stuck");
endmodule

// *** verification/brts_seq_tb_top.sv ***
// brts_seq_tb_top: self-checking bench for the reset sequencer
// assumes brts_seq with shortened counts and a free-running bench oscillator pair
`timescale 1ns/1ns
module brts_seq_tb_top;
	localparam logic [9:0] C_XTAL = 10'h300;
	localparam logic [9:0] C_SW = 10'h114;
	localparam logic [9:0] C_SLP = 10'h204;
	localparam logic [11:0] A_POWER_CONTROL_STATUS = 12'h238;
	localparam logic [11:0] A_STAT = 12'h20c;
	localparam logic [11:0] A_CFG = 12'h23c;
	logic mclk, rst, por_pulse, brownout_below, ext_reset_pin_n, low_freq_internal_osc, osc_clk_in;
	logic sleep_active, wdt_timeout, wake_event, wake_reset_event, two_speed_en;
	logic [9:0] cfg_word;
	logic [11:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest, core_reset, core_stall, run_on_internal_osc;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic [2:0] div;
	logic seen_int, seen_stall, hit;
	int err_total, n_tests, n;

	brts_seq #(.POWERUP_DELAY_TIMER_TICKS(4), .OST_TICKS(4), .BOD_CYC(3)) i_brts_seq (
		.mclk(mclk), .rst(rst), .por_pulse(por_pulse), .brownout_below(brownout_below),
		.ext_reset_pin_n(ext_reset_pin_n), .low_freq_internal_osc(low_freq_internal_osc),
		.osc_clk_in(osc_clk_in), .sleep_active(sleep_active), .wdt_timeout(wdt_timeout),
		.wake_event(wake_event), .wake_reset_event(wake_reset_event), .two_speed_en(two_speed_en),
		.cfg_word(cfg_word), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .core_reset(core_reset), .core_stall(core_stall),
		.run_on_internal_osc(run_on_internal_osc)
	);

	initial begin
		mclk = 0;
		forever #50 mclk = ~mclk;
	end

	// low-frequency tick every 8 cycles, main oscillator every 2
	always @(posedge mclk) begin
		div <= div + 3'h1;
		low_freq_internal_osc <= div[2];
		osc_clk_in <= div[0];
	end

	always @(negedge mclk) begin
		if (run_on_internal_osc === 1'b1) seen_int <= 1'b1;
		if (core_stall === 1'b1) seen_stall <= 1'b1;
	end

	task finish_test;
		if (err_total == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0 && k < 20) begin
			@(posedge mclk);
			k++;
		end
		if (k == 20) chk("waitrequest", 32'h0, 32'h1);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task rdc(input string what, input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, exp, rd & mask);
	endtask

	task wait_rel;
		n = 0;
		@(negedge mclk);
		while (core_reset !== 1'b0 && n < 400) begin
			@(negedge mclk);
			n++;
		end
		if (n == 400) chk("release", 32'h0, 32'h1);
		@(posedge mclk);
	endtask

	task watch(input int k);
		hit = 0;
		repeat (k) begin
			@(negedge mclk);
			if (core_reset === 1'b1) hit = 1;
		end
		@(posedge mclk);
	endtask

	task bo(input int len);
		@(posedge mclk);
		brownout_below <= 1'b1;
		repeat (len) @(posedge mclk);
		brownout_below <= 1'b0;
	endtask

	task dip(input int len);
		bo(len);
		watch(8);
		if (hit) wait_rel;
	endtask

	task pulse(input int which);
		@(posedge mclk);
		case (which)
			0: wdt_timeout <= 1'b1;
			1: wake_event <= 1'b1;
			default: wake_reset_event <= 1'b1;
		endcase
		@(posedge mclk);
		wdt_timeout <= 1'b0;
		wake_event <= 1'b0;
		wake_reset_event <= 1'b0;
	endtask

	task pwr_on(input logic [9:0] c, input int hold);
		@(posedge mclk);
		por_pulse <= 1'b1;
		cfg_word <= c;
		ext_reset_pin_n <= (hold == 0);
		repeat (4) @(posedge mclk);
		por_pulse <= 1'b0;
		seen_int <= 1'b0;
		if (hold > 0) begin
			repeat (hold) @(negedge mclk);
			chk("held by pin", 32'h1, core_reset);
			@(posedge mclk);
			ext_reset_pin_n <= 1'b1;
		end
		wait_rel;
	endtask

	task t_powerup;
		pwr_on(C_XTAL, 0);
		chk("power-up span", 32'h1, n > 28 && n < 90);
		chk("internal osc unused", 32'h0, seen_int);
		rdc("control after power-on", A_POWER_CONTROL_STATUS, 32'h3a, 32'h10);
		rdc("status after power-on", A_STAT, 32'h18, 32'h18);
		rdc("config", A_CFG, 32'hffffffff, {22'h0, C_XTAL});
		rdc("unmapped", 12'h004, 32'hffffffff, 32'h0);
	endtask

	task t_regs;
		bus(1'b1, A_POWER_CONTROL_STATUS, 32'h13);
		rdc("control written", A_POWER_CONTROL_STATUS, 32'h3b, 32'h13);
		bus(1'b1, A_STAT, 32'h0);
		rdc("status flags read-only", A_STAT, 32'hff, 32'h18);
		bus(1'b1, A_CFG, 32'h0);
		rdc("config read-only", A_CFG, 32'h3ff, {22'h0, C_XTAL});
	endtask

	task t_brownout;
		dip(2);
		chk("short dip", 32'h0, hit);
		dip(10);
		chk("long dip", 32'h1, hit);
		bo(10);
		repeat (20) @(posedge mclk);
		bo(10);
		wait_rel;
		chk("delay restarted", 32'h1, n > 28);
		rdc("flags after brown-out", A_POWER_CONTROL_STATUS, 32'h3, 32'h2);
		rdc("status after brown-out", A_STAT, 32'h18, 32'h18);
	endtask

	task t_watchdog;
		pulse(0);
		watch(6);
		chk("watchdog reset", 32'h1, hit);
		wait_rel;
		rdc("status after watchdog", A_STAT, 32'h18, 32'h08);
	endtask

	task t_pin;
		bus(1'b1, A_POWER_CONTROL_STATUS, 32'h13);
		@(posedge mclk);
		ext_reset_pin_n <= 1'b0;
		repeat (3) @(negedge mclk);
		chk("pin synchronised", 32'h0, core_reset);
		watch(4);
		chk("pin reset", 32'h1, hit);
		@(posedge mclk);
		ext_reset_pin_n <= 1'b1;
		wait_rel;
		chk("pin release", 32'h1, n < 8);
		rdc("flags after pin", A_POWER_CONTROL_STATUS, 32'h3, 32'h3);
		rdc("status after pin", A_STAT, 32'h18, 32'h08);
	endtask

	task t_sleep;
		@(posedge mclk);
		sleep_active <= 1'b1;
		pulse(0);
		watch(6);
		chk("watchdog wake", 32'h0, hit);
		rdc("status after wake", A_STAT, 32'h18, 32'h00);
		seen_stall <= 1'b0;
		pulse(1);
		sleep_active <= 1'b0;
		repeat (20) @(posedge mclk);
		chk("wake start-up wait", 32'h1, seen_stall);
		sleep_active <= 1'b1;
		ext_reset_pin_n <= 1'b0;
		repeat (6) @(posedge mclk);
		ext_reset_pin_n <= 1'b1;
		wait_rel;
		sleep_active <= 1'b0;
		rdc("status pin in sleep", A_STAT, 32'h18, 32'h10);
		bus(1'b1, A_POWER_CONTROL_STATUS, 32'h1b);
		sleep_active <= 1'b1;
		pulse(2);
		watch(6);
		wait_rel;
		sleep_active <= 1'b0;
		rdc("wake flag", A_POWER_CONTROL_STATUS, 32'h08, 32'h0);
		rdc("status wake reset", A_STAT, 32'h18, 32'h10);
	endtask

	task t_swmode;
		pwr_on(C_SW, 0);
		chk("no time-out", 32'h1, n < 8);
		bus(1'b1, A_POWER_CONTROL_STATUS, 32'h03);
		dip(10);
		chk("software off", 32'h0, hit);
		bus(1'b1, A_POWER_CONTROL_STATUS, 32'h13);
		dip(10);
		chk("software on", 32'h1, hit);
	endtask

	task t_slpmode;
		pwr_on(C_SLP, 0);
		chk("delay only", 32'h1, n > 23 && n < 60);
		bus(1'b1, A_POWER_CONTROL_STATUS, 32'h03);
		dip(10);
		chk("awake detection", 32'h1, hit);
		sleep_active <= 1'b1;
		dip(10);
		chk("asleep detection", 32'h0, hit);
		sleep_active <= 1'b0;
	endtask

	task t_pinhold;
		two_speed_en <= 1'b1;
		pwr_on(C_XTAL, 0);
		chk("internal osc used", 32'h1, seen_int);
		two_speed_en <= 1'b0;
		pwr_on(C_XTAL, 100);
		chk("immediate start", 32'h1, n < 6);
	endtask

	initial begin
		err_total = 0;
		n_tests = 0;
		rst = 1'b1;
		div = 3'h0;
		{por_pulse, brownout_below, sleep_active, wdt_timeout, wake_event, wake_reset_event} = 6'h20;
		{two_speed_en, avs_read, avs_write, seen_int, seen_stall} = 5'h0;
		ext_reset_pin_n = 1'b1;
		cfg_word = C_XTAL;
		avs_address = 12'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		t_powerup;
		t_regs;
		t_brownout;
		t_watchdog;
		t_pin;
		t_sleep;
		t_swmode;
		t_slpmode;
		t_pinhold;
		finish_test;
	end

	initial begin
		#2000000;
		err_total++;
		finish_test;
	end
endmodule
